// File: verilog/dmcp_port.sv
// Purpose: dual-mode control port, two-wire or four-wire register access
// Assumes: user register file answers reads in the cycle reg_rd_o is high
// Notes: two-wire pins oversampled on mclk_i; ce_i freezes mclk state only
`default_nettype none

// Behaviour
// - first valid two-wire start or four-wire request locks the mode until reset.
// - data line is only pulled low; a one releases it.
// - device address byte carries direction in its lsb, one means read.
// - own write address is 0x90 plus twice the three-bit strap code.
// - start is data falling with clock high; next eight bits, msb first.
// - a matching device address is acknowledged by pulling data low.
// - mismatch or bad direction gives no acknowledge and returns to idle.
// - stop is data rising with clock high; device then waits idle.
// - start or stop out of sequence abandons the transfer.
// - two-wire register address and data words are two bytes each.
// - two-wire bursts step the register address after every word.
// - four-wire reads ignore data input after the register address.
// - four-wire output driven only while selected and shifting read data.
// - output bits are stable for capture on the rising serial clock.
// - four-wire frame is direction, 15-bit address, 16 pad bits, words.
// - four-wire bursts step the address after every sixteen-clock word.
// - registers are whole 16-bit words only.
module dmcp_port
    import dmcp_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic i2c_scl_i,
    input wire logic i2c_sda_i,
    output logic i2c_sda_o,
    output logic i2c_sda_oe_o,
    input wire logic [STRAP_W-1:0] address_strap_pin_i,
    input wire logic spi_sck_i,
    input wire logic spi_cs_n_i,
    input wire logic four_wire_data_in_pin_i,
    output logic four_wire_data_out_pin_o,
    output logic four_wire_data_out_pin_oe_o,
    output logic [REG_AW-1:0] reg_addr_o,
    output logic [REG_DW-1:0] reg_wdata_o,
    output logic reg_wr_o,
    output logic reg_rd_o,
    input wire logic [REG_DW-1:0] reg_rdata_i,
    output logic mode_i2c_o,
    output logic mode_spi_o
);
    dmcp_xfer_if xif ();

    logic scl_s1_q;
    logic scl_s2_q;
    logic scl_p_q;
    logic sda_s1_q;
    logic sda_s2_q;
    logic sda_p_q;
    logic [STRAP_W-1:0] strap_s1_q;
    logic [STRAP_W-1:0] strap_s2_q;
    logic tgl_s1_q;
    logic tgl_s2_q;
    logic tgl_p_q;

    logic scl_rise;
    logic scl_fall;
    logic i2c_start;
    logic i2c_stop;
    logic spi_req;

    dmcp_i2c_st_t st_q;
    logic [3:0] bit_q;
    logic [BYTE_W-1:0] sh_q;
    logic [BYTE_W-1:0] data_hi_q;
    logic [1:0] byte_q;
    logic tx_lo_q;
    logic addr_ok_q;
    logic [REG_AW-1:0] i2c_addr_q;
    logic [REG_DW-1:0] i2c_wdata_q;
    logic i2c_wr_q;
    logic i2c_rd_q;
    logic [REG_DW-1:0] rd_word_q;

    logic [6:0] own_addr;
    logic dev_match;
    logic [BYTE_W-1:0] tx_byte;
    logic tx_bit;

    // pin synchronisers; only the second stage and the edge stage after it are looked at
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            scl_s1_q <= 1'b1;
            scl_s2_q <= 1'b1;
            scl_p_q <= 1'b1;
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
            sda_p_q <= 1'b1;
            strap_s1_q <= '0;
            strap_s2_q <= '0;
        end
        else if (ce_i)
        begin
            scl_s1_q <= i2c_scl_i;
            scl_s2_q <= scl_s1_q;
            scl_p_q <= scl_s2_q;
            sda_s1_q <= i2c_sda_i;
            sda_s2_q <= sda_s1_q;
            sda_p_q <= sda_s2_q;
            strap_s1_q <= address_strap_pin_i;
            strap_s2_q <= strap_s1_q;
        end
    end

    // request toggle from the link domain; payload is stable by then
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            tgl_s1_q <= 1'b0;
            tgl_s2_q <= 1'b0;
            tgl_p_q <= 1'b0;
        end
        else if (ce_i)
        begin
            tgl_s1_q <= xif.req_tgl;
            tgl_s2_q <= tgl_s1_q;
            tgl_p_q <= tgl_s2_q;
        end
    end

    assign scl_rise = scl_s2_q & ~scl_p_q;
    assign scl_fall = ~scl_s2_q & scl_p_q;
    assign i2c_start = scl_s2_q & scl_p_q & sda_p_q & ~sda_s2_q;
    assign i2c_stop = scl_s2_q & scl_p_q & ~sda_p_q & sda_s2_q;
    assign spi_req = (tgl_s2_q ^ tgl_p_q) & ~mode_i2c_o;

    assign own_addr = I2C_DEV_BASE + {4'h0, strap_s2_q};
    // a read is only sensible once a register address has been set
    assign dev_match = (sh_q[BYTE_W-1:1] == own_addr)
        && (!sh_q[0] || addr_ok_q);
    assign tx_byte = tx_lo_q ? rd_word_q[BYTE_W-1:0]
                             : rd_word_q[REG_DW-1:BYTE_W];
    assign tx_bit = tx_byte[I2C_MSB - bit_q[2:0]];

    assign xif.rd_word = rd_word_q;
    assign xif.spi_en = ~mode_i2c_o;

    // the mode is taken once and never given up until reset
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            mode_i2c_o <= 1'b0;
            mode_spi_o <= 1'b0;
        end
        else if (ce_i && !mode_i2c_o && !mode_spi_o)
        begin
            if (i2c_start)
                mode_i2c_o <= 1'b1;
            else if (spi_req)
                mode_spi_o <= 1'b1;
        end
    end

    // two-wire engine: sample on clock rise, change drive on clock fall
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st_q <= I2C_IDLE;
            bit_q <= '0;
            sh_q <= '0;
            data_hi_q <= '0;
            byte_q <= BYTE_ADDR_HI;
            tx_lo_q <= 1'b0;
            addr_ok_q <= 1'b0;
            i2c_addr_q <= '0;
            i2c_wdata_q <= '0;
            i2c_wr_q <= 1'b0;
            i2c_rd_q <= 1'b0;
            i2c_sda_oe_o <= 1'b0;
        end
        else if (ce_i)
        begin
            i2c_rd_q <= 1'b0;
            i2c_wr_q <= 1'b0;
            if (i2c_wr_q)
                i2c_addr_q <= i2c_addr_q + I2C_ADDR_STEP;
            if (i2c_start && !mode_spi_o)
            begin
                st_q <= I2C_DEV;
                bit_q <= '0;
                i2c_sda_oe_o <= 1'b0;
            end
            else if (i2c_stop || (i2c_start && mode_spi_o))
            begin
                st_q <= I2C_IDLE;
                i2c_sda_oe_o <= 1'b0;
            end
            else if (st_q != I2C_IDLE && scl_rise)
            begin
                if (bit_q == I2C_ACK_SLOT)
                begin
                    bit_q <= '0;
                    if (st_q == I2C_DEV)
                        st_q <= sh_q[0] ? I2C_TX : I2C_RX;
                    else if (st_q == I2C_TX && sda_s2_q)
                        st_q <= I2C_IDLE;
                    else if (st_q == I2C_TX)
                    begin
                        tx_lo_q <= ~tx_lo_q;
                        if (tx_lo_q)
                        begin
                            i2c_addr_q <= i2c_addr_q + I2C_ADDR_STEP;
                            i2c_rd_q <= 1'b1;
                        end
                    end
                end
                else
                begin
                    sh_q <= {sh_q[BYTE_W-2:0], sda_s2_q};
                    bit_q <= bit_q + 4'h1;
                end
            end
            else if (st_q != I2C_IDLE && scl_fall)
            begin
                if (bit_q != I2C_ACK_SLOT)
                    i2c_sda_oe_o <= (st_q == I2C_TX) && !tx_bit;
                else if (st_q == I2C_DEV)
                begin
                    if (dev_match)
                    begin
                        i2c_sda_oe_o <= 1'b1;
                        byte_q <= BYTE_ADDR_HI;
                        tx_lo_q <= 1'b0;
                        i2c_rd_q <= sh_q[0];
                    end
                    else
                        st_q <= I2C_IDLE;
                end
                else if (st_q == I2C_RX)
                begin
                    i2c_sda_oe_o <= 1'b1;
                    byte_q <= byte_q + 2'h1;
                    case (byte_q)
                        BYTE_ADDR_HI:
                            i2c_addr_q[REG_AW-1:BYTE_W] <= sh_q;
                        BYTE_ADDR_LO:
                        begin
                            i2c_addr_q[BYTE_W-1:0] <= sh_q;
                            addr_ok_q <= 1'b1;
                        end
                        BYTE_DATA_HI:
                            data_hi_q <= sh_q;
                        default:
                        begin
                            // whole word only, then wait for the next pair
                            i2c_wdata_q <= {data_hi_q, sh_q};
                            i2c_wr_q <= 1'b1;
                            byte_q <= BYTE_DATA_HI;
                        end
                    endcase
                end
                else
                    i2c_sda_oe_o <= 1'b0;
            end
        end
    end

    // data line only ever pulled low
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
            i2c_sda_o <= 1'b0;
        else
            i2c_sda_o <= 1'b0;
    end

    // register access port, shared by whichever mode is locked
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            reg_addr_o <= '0;
            reg_wdata_o <= '0;
            reg_wr_o <= 1'b0;
            reg_rd_o <= 1'b0;
        end
        else if (ce_i)
        begin
            reg_wr_o <= 1'b0;
            reg_rd_o <= 1'b0;
            if (mode_i2c_o)
            begin
                if (i2c_wr_q)
                begin
                    reg_addr_o <= i2c_addr_q;
                    reg_wdata_o <= i2c_wdata_q;
                    reg_wr_o <= 1'b1;
                end
                else if (i2c_rd_q)
                begin
                    reg_addr_o <= i2c_addr_q;
                    reg_rd_o <= 1'b1;
                end
            end
            else if (spi_req)
            begin
                // word address onto the byte-addressed register map
                reg_addr_o <= {xif.req_addr, 1'b0};
                reg_wdata_o <= xif.req_data;
                reg_wr_o <= xif.req_wr;
                reg_rd_o <= ~xif.req_wr;
            end
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
            rd_word_q <= '0;
        else if (ce_i && reg_rd_o)
            rd_word_q <= reg_rdata_i;
    end

    dmcp_spi_link u_link (
        .rst_i(rst_i),
        .sck_i(spi_sck_i),
        .cs_n_i(spi_cs_n_i),
        .sdi_i(four_wire_data_in_pin_i),
        .sdo_o(four_wire_data_out_pin_o),
        .sdo_oe_o(four_wire_data_out_pin_oe_o),
        .xif(xif.link)
    );
endmodule

`default_nettype wire

// File: verilog/dmcp_pkg.sv
// Purpose: shared constants and types of the dual-mode control port
// Assumes: 16-bit register words; two-wire bus oversampled on mclk_i
// Notes: four-wire side runs on its own serial clock
`default_nettype none

package dmcp_pkg;
    localparam int REG_AW = 16;
    localparam int REG_DW = 16;
    localparam int SPI_AW = 15;
    localparam int BYTE_W = 8;
    localparam int STRAP_W = 3;
    // four-wire header, pad and each data word are sixteen clocks long
    localparam logic [3:0] SPI_LAST_BIT = 4'hF;
    localparam logic [3:0] I2C_ACK_SLOT = 4'h8;
    localparam logic [2:0] I2C_MSB = 3'h7;
    // write address 0x90 shifted down past the direction bit
    localparam logic [6:0] I2C_DEV_BASE = 7'h48;
    localparam logic [15:0] I2C_ADDR_STEP = 16'h0002;
    localparam logic [14:0] SPI_ADDR_STEP = 15'h0001;
    localparam logic [1:0] BYTE_ADDR_HI = 2'h0;
    localparam logic [1:0] BYTE_ADDR_LO = 2'h1;
    localparam logic [1:0] BYTE_DATA_HI = 2'h2;
    localparam logic [1:0] BYTE_DATA_LO = 2'h3;

    typedef enum logic [1:0] {
        I2C_IDLE,
        I2C_DEV,
        I2C_RX,
        I2C_TX
    } dmcp_i2c_st_t;

    typedef enum logic [1:0] {
        SPI_HDR,
        SPI_PAD,
        SPI_DATA
    } dmcp_spi_ph_t;
endpackage

`default_nettype wire

// File: verilog/dmcp_xfer_if.sv
// Purpose: request and read-word carrier between link and core domains
// Assumes: payload is held stable from one toggle to the next
// Notes: link drives requests on sck, core answers on mclk
`default_nettype none

interface dmcp_xfer_if;
    import dmcp_pkg::*;
    logic req_tgl;
    logic req_wr;
    logic [SPI_AW-1:0] req_addr;
    logic [REG_DW-1:0] req_data;
    logic [REG_DW-1:0] rd_word;
    logic spi_en;

    modport link (
        output req_tgl,
        output req_wr,
        output req_addr,
        output req_data,
        input rd_word,
        input spi_en
    );

    modport core (
        input req_tgl,
        input req_wr,
        input req_addr,
        input req_data,
        output rd_word,
        output spi_en
    );
endinterface

`default_nettype wire

// File: verilog/dmcp_spi_link.sv
// Purpose: four-wire framing on the serial clock of the host
// Assumes: sck idles low, data sampled on rising edge, msb first
// Notes: chip select high resets the frame asynchronously
`default_nettype none

module dmcp_spi_link
    import dmcp_pkg::*;
(
    input wire logic rst_i,
    input wire logic sck_i,
    input wire logic cs_n_i,
    input wire logic sdi_i,
    output logic sdo_o,
    output logic sdo_oe_o,
    dmcp_xfer_if.link xif
);
    logic frame_rst;
    logic en_s1_q;
    logic en_s2_q;
    dmcp_spi_ph_t ph_q;
    logic [3:0] cnt_q;
    logic [REG_DW-1:0] sh_q;
    logic [REG_DW-1:0] out_q;
    logic rw_q;
    logic [SPI_AW-1:0] ptr_q;
    logic [REG_DW-1:0] word;
    logic last;

    assign frame_rst = rst_i | cs_n_i;
    assign word = {sh_q[REG_DW-2:0], sdi_i};
    assign last = en_s2_q && (cnt_q == SPI_LAST_BIT);

    always_ff @(posedge sck_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            en_s1_q <= 1'b0;
            en_s2_q <= 1'b0;
        end
        else
        begin
            en_s1_q <= xif.spi_en;
            en_s2_q <= en_s1_q;
        end
    end

    always_ff @(posedge sck_i or posedge frame_rst)
    begin
        if (frame_rst)
        begin
            ph_q <= SPI_HDR;
            cnt_q <= '0;
            sh_q <= '0;
            out_q <= '0;
            rw_q <= 1'b0;
        end
        else if (en_s2_q)
        begin
            cnt_q <= cnt_q + 4'h1;
            if (ph_q == SPI_HDR || !rw_q)
                sh_q <= word;
            if (ph_q == SPI_DATA)
                out_q <= {out_q[REG_DW-2:0], 1'b0};
            if (last)
            begin
                case (ph_q)
                    SPI_HDR:
                    begin
                        rw_q <= word[REG_DW-1];
                        ph_q <= SPI_PAD;
                    end
                    SPI_PAD:
                    begin
                        ph_q <= SPI_DATA;
                        out_q <= xif.rd_word;
                    end
                    default:
                    begin
                        if (rw_q)
                            out_q <= xif.rd_word;
                    end
                endcase
            end
        end
    end

    // reads prefetch one word ahead, so the core has a full word time
    always_ff @(posedge sck_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            xif.req_tgl <= 1'b0;
            xif.req_wr <= 1'b0;
            xif.req_addr <= '0;
            xif.req_data <= '0;
            ptr_q <= '0;
        end
        else if (last)
        begin
            if (ph_q == SPI_HDR)
            begin
                ptr_q <= word[SPI_AW-1:0];
                if (word[REG_DW-1])
                begin
                    xif.req_addr <= word[SPI_AW-1:0];
                    xif.req_wr <= 1'b0;
                    xif.req_tgl <= ~xif.req_tgl;
                    ptr_q <= word[SPI_AW-1:0] + SPI_ADDR_STEP;
                end
            end
            else if (rw_q || ph_q == SPI_DATA)
            begin
                xif.req_addr <= ptr_q;
                xif.req_wr <= ~rw_q;
                xif.req_data <= word;
                xif.req_tgl <= ~xif.req_tgl;
                ptr_q <= ptr_q + SPI_ADDR_STEP;
            end
        end
    end

    // change on the falling edge so the host samples on the rising one
    always_ff @(negedge sck_i or posedge frame_rst)
    begin
        if (frame_rst)
        begin
            sdo_o <= 1'b0;
            sdo_oe_o <= 1'b0;
        end
        else
        begin
            sdo_o <= out_q[REG_DW-1];
            sdo_oe_o <= en_s2_q && rw_q && (ph_q == SPI_DATA);
        end
    end
endmodule

`default_nettype wire

// File: tb/dmcp_port_props.sv
// Purpose: port-level checks of the dual-mode control port
// Assumes: both links are watched as levels sampled on mclk_i
// Notes: bound to every dmcp_port instance
`default_nettype none

module dmcp_port_props
    import dmcp_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic i2c_scl_i,
    input wire logic i2c_sda_o,
    input wire logic i2c_sda_oe_o,
    input wire logic spi_cs_n_i,
    input wire logic four_wire_data_out_pin_oe_o,
    input wire logic [REG_AW-1:0] reg_addr_o,
    input wire logic reg_wr_o,
    input wire logic reg_rd_o,
    input wire logic mode_i2c_o,
    input wire logic mode_spi_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);

    // the register side is slow, strobes must leave it a gap
    sequence s_reg_quiet;
        (!reg_wr_o && !reg_rd_o) [*5];
    endsequence
    sequence s_locked;
        mode_i2c_o || mode_spi_o;
    endsequence

    sda_low_only_a:
        assert property (i2c_sda_oe_o |-> !i2c_sda_o)
        else $error("data line driven high");
    mode_single_a:
        assert property (!(mode_i2c_o && mode_spi_o))
        else $error("both modes locked");
    mode_hold_a:
        assert property (s_locked |=> $stable({mode_i2c_o, mode_spi_o}))
        else $error("locked mode changed");
    mode_clear_a:
        assert property ($fell(rst_i) |-> !mode_i2c_o && !mode_spi_o)
        else $error("mode set at reset release");
    sdo_cs_a:
        assert property (spi_cs_n_i [*2] |-> !four_wire_data_out_pin_oe_o)
        else $error("serial output driven while deselected");
    sdo_mode_a:
        assert property (four_wire_data_out_pin_oe_o |-> !mode_i2c_o)
        else $error("serial output driven in two-wire mode");
    sda_mode_a:
        assert property (i2c_sda_oe_o |-> !mode_spi_o)
        else $error("data line pulled in four-wire mode");
    ack_on_low_a:
        assert property ($rose(i2c_sda_oe_o) |-> !i2c_scl_i)
        else $error("data line changed while clock high");
    reg_gap_a:
        assert property ((reg_wr_o || reg_rd_o) |=> s_reg_quiet)
        else $error("register strobes too close");
    reg_even_a:
        assert property ((reg_wr_o || reg_rd_o) |-> !reg_addr_o[0])
        else $error("odd register address");
endmodule

bind dmcp_port dmcp_port_props u_dmcp_port_props (.mclk_i, .rst_i,
    .i2c_scl_i, .i2c_sda_o, .i2c_sda_oe_o, .spi_cs_n_i,
    .four_wire_data_out_pin_oe_o, .reg_addr_o, .reg_wr_o, .reg_rd_o,
    .mode_i2c_o, .mode_spi_o);

`default_nettype wire

// File: tb/dmcp_host_model.sv
// Purpose: behavioural host controller for both control links
// Assumes: data line has a pull-up; serial clock idles low
// Notes: serial clock only runs inside the word task
`default_nettype none

module dmcp_host_model (
    input wire logic mclk_i,
    input wire logic sda_oe_i,
    input wire logic sdo_i,
    input wire logic sdo_oe_i,
    output logic scl_o,
    output logic sda_o,
    output logic sck_o,
    output logic cs_n_o,
    output logic sdi_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic sda_lo;
    logic sdo_last;
    logic sdo_w;

    // open-drain line: low if any party pulls, else pull-up
    assign sda_o = !(sda_oe_i || sda_lo);
    // released output shows the inverse of its last value
    assign sdo_w = sdo_oe_i ? sdo_i : !sdo_last;
    always @(sdo_i) if (sdo_oe_i) sdo_last = sdo_i;

    initial
    begin
        scl_o = 1'b1;
        sda_lo = 1'b0;
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        sdi_o = 1'b0;
        sdo_last = 1'b0;
    end

    task automatic hw(input int n);
        repeat (n) @(negedge mclk_i);
    endtask

    // also serves as repeated start after a low clock
    task automatic i2c_start();
        sda_lo = 1'b0;
        hw(8);
        scl_o = 1'b1;
        hw(8);
        sda_lo = 1'b1;
        hw(8);
        scl_o = 1'b0;
        hw(8);
    endtask

    task automatic i2c_stop();
        sda_lo = 1'b1;
        hw(8);
        scl_o = 1'b1;
        hw(8);
        sda_lo = 1'b0;
        hw(8);
    endtask

    task automatic i2c_bit(input logic b, output logic r);
        sda_lo = !b;
        hw(8);
        scl_o = 1'b1;
        hw(8);
        r = sda_o;
        hw(8);
        scl_o = 1'b0;
        hw(8);
    endtask

    // ack_in high lets the device answer, low acknowledges a read byte
    task automatic i2c_byte(input logic [7:0] tx, input logic ack_in,
        output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) i2c_bit(tx[i], rx[i]);
        i2c_bit(ack_in, ack);
    endtask

    task automatic spi_cs(input logic v);
        #100 cs_n_o = v;
        #100;
    endtask

    task automatic spi_word(input logic [15:0] tx, output logic [15:0] rx);
        for (int i = 15; i >= 0; i--)
        begin
            sdi_o = tx[i];
            #62.5 sck_o = 1'b1;
            rx[i] = sdo_w;
            #62.5 sck_o = 1'b0;
        end
    endtask
endmodule

`default_nettype wire

// File: tb/test_dmcp_port.sv
// Purpose: self-checking bench of the dual-mode control port
// Assumes: register file answers with address xor a fixed pattern
// Notes: one mode per reset, so the run resets between the two links
`default_nettype none

module test_dmcp_port;
    import dmcp_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, rst, scl, sda, sda_o, sda_oe, sck, cs_n, sdi, sdo, sdo_oe;
    logic wr, rd, m_i2c, m_spi;
    logic [2:0] strap;
    logic [15:0] raddr, wdata, rdata;
    logic [31:0] wlog[$];
    int fail_count;
    int n_tests;
    int n_rd;

    function automatic logic [15:0] rv(input logic [15:0] a);
        return a ^ 16'hA5C3;
    endfunction

    assign rdata = rv(raddr);
    always @(posedge mclk) if (wr === 1'b1) wlog.push_back({raddr, wdata});
    always @(posedge mclk) if (rd === 1'b1) n_rd++;

    dmcp_port u_dmcp_port (.mclk_i(mclk), .rst_i(rst), .ce_i(1'b1),
        .i2c_scl_i(scl), .i2c_sda_i(sda), .i2c_sda_o(sda_o),
        .i2c_sda_oe_o(sda_oe), .address_strap_pin_i(strap),
        .spi_sck_i(sck), .spi_cs_n_i(cs_n), .four_wire_data_in_pin_i(sdi),
        .four_wire_data_out_pin_o(sdo), .four_wire_data_out_pin_oe_o(sdo_oe),
        .reg_addr_o(raddr), .reg_wdata_o(wdata), .reg_wr_o(wr),
        .reg_rd_o(rd), .reg_rdata_i(rdata), .mode_i2c_o(m_i2c),
        .mode_spi_o(m_spi));

    dmcp_host_model u_host (.mclk_i(mclk), .sda_oe_i(sda_oe), .sdo_i(sdo),
        .sdo_oe_i(sdo_oe), .scl_o(scl), .sda_o(sda), .sck_o(sck),
        .cs_n_o(cs_n), .sdi_o(sdi));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        if (fail_count == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic do_reset();
        rst = 1'b1;
        repeat (8) @(negedge mclk);
        rst = 1'b0;
        repeat (80) @(negedge mclk);
    endtask

    task automatic send(input logic [7:0] b, input logic exp_ack);
        logic [7:0] rx;
        logic ack;
        u_host.i2c_byte(b, 1'b1, rx, ack);
        chk({31'h0, ack}, {31'h0, exp_ack});
    endtask

    task automatic spi_frame(input logic [15:0] w0, w1, w2, w3,
        output logic [15:0] r2, r3);
        logic [15:0] junk;
        u_host.spi_cs(1'b0);
        u_host.spi_word(w0, junk);
        u_host.spi_word(w1, junk);
        u_host.spi_word(w2, r2);
        u_host.spi_word(w3, r3);
        u_host.spi_cs(1'b1);
        repeat (20) @(negedge mclk);
    endtask

    task automatic t_strap();
        logic [7:0] own;
        logic [15:0] r2, r3;
        for (int k = 0; k < 8; k++)
        begin
            strap = k[2:0];
            own = 8'h90 + 8'(2 * k);
            u_host.i2c_start();
            send(own, 1'b0);
            u_host.i2c_start();
            send(own ^ 8'h02, 1'b1);
            u_host.i2c_start();
            send(own | 8'h01, 1'b1);
            u_host.i2c_stop();
        end
        chk({30'h0, m_spi, m_i2c}, 32'h1);
        spi_frame(16'h1000, 16'h0000, 16'h0001, 16'h0002, r2, r3);
        chk(32'(wlog.size()), 32'h0);
    endtask

    task automatic t_i2c_write();
        strap = 3'h5;
        u_host.i2c_start();
        send(8'h9A, 1'b0);
        send(8'h00, 1'b0);
        send(8'h40, 1'b0);
        send(8'h12, 1'b0);
        send(8'h34, 1'b0);
        send(8'hBE, 1'b0);
        send(8'hEF, 1'b0);
        u_host.i2c_stop();
        u_host.i2c_start();
        send(8'h9A, 1'b0);
        send(8'h00, 1'b0);
        send(8'h60, 1'b0);
        send(8'h55, 1'b0);
        // a start inside a word must drop the half word
        u_host.i2c_start();
        send(8'h9A, 1'b0);
        u_host.i2c_stop();
        chk(32'(wlog.size()), 32'h2);
        chk(wlog[0], 32'h0040_1234);
        chk(wlog[1], 32'h0042_BEEF);
    endtask

    task automatic t_i2c_read();
        logic [7:0] rx [4];
        logic a;
        int n0;
        n0 = n_rd;
        u_host.i2c_start();
        send(8'h9A, 1'b0);
        send(8'h00, 1'b0);
        send(8'h80, 1'b0);
        u_host.i2c_start();
        send(8'h9B, 1'b0);
        for (int i = 0; i < 4; i++) u_host.i2c_byte(8'hFF, i == 3, rx[i], a);
        u_host.i2c_stop();
        chk({rx[0], rx[1], rx[2], rx[3]}, {rv(16'h80), rv(16'h82)});
        chk(32'(n_rd - n0), 32'h2);
    endtask

    task automatic t_spi();
        logic [15:0] r2, r3;
        logic [7:0] rx;
        logic a;
        int n0;
        wlog.delete();
        // a few idle clocks so the link sees its enable first
        u_host.spi_word(16'h0000, r2);
        spi_frame(16'h1000, 16'h0000, 16'h0001, 16'hC3A5, r2, r3);
        chk({30'h0, m_spi, m_i2c}, 32'h2);
        chk(wlog[0], 32'h2000_0001);
        chk(wlog[1], 32'h2002_C3A5);
        n0 = n_rd;
        spi_frame(16'h8010, 16'h0000, 16'hFFFF, 16'h5A5A, r2, r3);
        chk({r2, r3}, {rv(16'h0020), rv(16'h0022)});
        chk(32'(n_rd - n0), 32'h4);
        chk(32'(wlog.size()), 32'h2);
        u_host.i2c_start();
        u_host.i2c_byte(8'h9A, 1'b1, rx, a);
        u_host.i2c_stop();
        chk({31'h0, a}, 32'h1);
    endtask

    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    initial
    begin
        #600us;
        fail_count++;
        wrap_up();
    end

    initial
    begin
        fail_count = 0;
        n_tests = 0;
        strap = 3'h0;
        rst = 1'b1;
        do_reset();
        t_strap();
        t_i2c_write();
        t_i2c_read();
        do_reset();
        t_spi();
        wrap_up();
    end
endmodule

`default_nettype wire
